// [core/dcc_arbiter.sv]
// fixed-priority channel arbiter: high level first, then lowest index
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_arbiter
  import dcc_pkg::*;
(
  input wire logic [`DCC_NCH-1:0] req,
  input wire logic [`DCC_NCH-1:0] high,
  output logic valid,
  output logic [1:0] idx
);
  logic [`DCC_NCH-1:0] req_high;
  assign req_high = req & high;
  always_comb begin
    valid = |req;
    idx = 2'h0;
    // high level first, ties to lowest index
    // descending scan so the lowest index is the last one kept
    for (int i = `DCC_NCH - 1; i >= 0; i--) begin
      if (req_high != '0) begin
        if (req_high[i]) begin
          idx = 2'(i);
        end
      end else if (req[i]) begin
        idx = 2'(i);
      end
    end
  end
endmodule

// [core/dcc_channel_ctrl.sv]
// multi-channel dma control: attributes, structures, requests, item engine
//
// Functional notes
// - burst-only attribute makes a channel ignore single requests
// - alternate-structure attribute picks the active structure of a channel
// - high-priority channels win over default-priority ones in arbitration
// - request-mask attribute ignores the mapped peripheral hardware request
// - all four attribute flags of every channel read back together
// - each channel owns a primary and an alternate structure, separately addressed
// - item size field selects 8, 16 or 32 bit items
// - source pointer steps by byte, halfword, word or stays fixed
// - destination pointer steps by byte, halfword, word or stays fixed
// - re-arbitrate after arbitration-size items on burst requests (a power of two up to 1024), after every item on single requests
// - burst-at-tail flag allows only burst requests on last peripheral gather task
// - disabled channel answers no request until enabled again
// - completion clears the channel enable automatically
// - channel enable state reads back as a boolean
// - mode field readable; hardware writes stop on completion
// - software request starts a transfer like a peripheral request
// - software channel completion raises own interrupt, others the peripheral's
// - scatter-gather runs a task count, mode field selects peripheral or memory; the flag is only stored and read back
// - per-channel default or secondary request source, many set per write
// - remaining item count readable, zero once complete
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_channel_ctrl
  import dcc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [`DCC_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [`DCC_NCH-1:0] BURST_REQ,
  input wire logic [`DCC_NCH-1:0] SINGLE_REQ,
  input wire logic [`DCC_NCH-1:0] SEC_BURST_REQ,
  input wire logic [`DCC_NCH-1:0] SEC_SINGLE_REQ,
  output logic ITEM_STB,
  output logic [1:0] ITEM_CH,
  output logic [1:0] ITEM_SIZE,
  output logic [31:0] ITEM_SRC,
  output logic [31:0] ITEM_DST,
  output logic DMA_IRQ,
  output logic [`DCC_NCH-1:0] PERIPH_DONE
);
  localparam int NS = 2 * `DCC_NCH;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  logic [`DCC_NCH-1:0] en_reg;
  logic [`DCC_AT_W*`DCC_NCH-1:0] attr_reg;
  logic [`DCC_NCH-1:0] sec_sel_reg;
  logic [`DCC_NCH-1:0] pend_reg;
  logic [`DCC_NCH-1:0] pend_burst_reg;
  logic [`DCC_CNT_W-1:0] tasks_reg [`DCC_NCH];
  logic [`DCC_NCH-1:0] psg_reg;
  logic [`DCC_CTL_W-1:0] ctl_reg [NS];
  logic [31:0] src_reg [NS];
  logic [31:0] dst_reg [NS];
  logic [`DCC_CNT_W-1:0] cnt_reg [NS];
  logic [`DCC_CNT_W-1:0] init_reg [NS];
  dcc_state_t state_reg;
  logic [1:0] ch_reg;
  logic [`DCC_CNT_W-1:0] chunk_reg;

  logic [`DCC_NCH-1:0] burst_only_attr;
  logic [`DCC_NCH-1:0] alternate_struct_attr;
  logic [`DCC_NCH-1:0] high_attr;
  logic [`DCC_NCH-1:0] request_mask_attr;
  logic [`DCC_NCH-1:0] req_set;
  logic [`DCC_NCH-1:0] req_burst;
  logic gnt_valid;
  logic [1:0] gnt_idx;
  logic [2:0] s_idx;
  logic [2:0] bus_sidx;
  logic [1:0] bus_word;
  logic wr_struct;
  logic [`DCC_CTL_W-1:0] act_ctl;
  dcc_mode_t act_mode;
  dcc_mode_t other_mode;
  logic [3:0] arb_exp;
  logic [`DCC_CNT_W-1:0] chunk_load;
  logic is_sg;
  logic more_tasks;
  logic fin;
  logic keep_going;
  logic go;
  logic chunk_end;
  logic sw_req_w;

  function automatic logic [31:0] step_of(input logic [1:0] code);
    step_of = (code == `DCC_INC_NONE) ? 32'h0 : (32'h1 << code);
  endfunction

  assign s_idx = {ch_reg, alternate_struct_attr[ch_reg]};
  assign bus_sidx = ADDR[`DCC_F_SIDX];
  assign bus_word = ADDR[`DCC_F_WORD];
  assign wr_struct = WR && ADDR[`DCC_B_STRUCT];
  assign act_ctl = ctl_reg[s_idx];
  assign act_mode = dcc_mode_t'(act_ctl[`DCC_F_MODE]);
  assign other_mode = dcc_mode_t'(ctl_reg[s_idx ^ 3'h1][`DCC_F_MODE]);
  // oversize arbitration codes clamp to arb_size_max
  assign arb_exp = (act_ctl[`DCC_F_ARB] > `DCC_ARB_MAX) ? `DCC_ARB_MAX : act_ctl[`DCC_F_ARB];
  assign chunk_load = pend_burst_reg[ch_reg] ? (`DCC_CNT_W'(1) << arb_exp) : `DCC_CNT_W'(1);
  assign is_sg = (act_mode == mode_mem_sg) || (act_mode == mode_periph_sg);
  assign more_tasks = is_sg && (tasks_reg[ch_reg] > `DCC_CNT_W'(1));
  assign fin = (act_mode == mode_ping_pong) ? (other_mode == mode_stop) : !more_tasks;
  assign keep_going = (act_mode == mode_auto) || (act_mode == mode_mem_sg);
  // a disabled or stopped channel is dropped at grant
  assign go = en_reg[ch_reg] && (act_mode != mode_stop) && (cnt_reg[s_idx] != '0);
  assign chunk_end = (state_reg == ST_MOVE) && (cnt_reg[s_idx] != `DCC_CNT_W'(1))
                     && (chunk_reg == `DCC_CNT_W'(1));
  assign sw_req_w = WR && (ADDR == `DCC_A_SW_REQ);

  genvar c;
  generate
    for (c = 0; c < `DCC_NCH; c++) begin : g_ch
      logic hw_burst;
      logic hw_single;
      logic tail_burst;
      logic [2:0] cs;
      assign cs = {2'(c), alternate_struct_attr[c]};
      assign burst_only_attr[c] = attr_reg[`DCC_AT_W*c + `DCC_AT_BURST];
      assign alternate_struct_attr[c] = attr_reg[`DCC_AT_W*c + `DCC_AT_ALT];
      assign high_attr[c] = attr_reg[`DCC_AT_W*c + `DCC_AT_HIGH];
      assign request_mask_attr[c] = attr_reg[`DCC_AT_W*c + `DCC_AT_MASK];
      assign hw_burst = sec_sel_reg[c] ? SEC_BURST_REQ[c] : BURST_REQ[c];
      assign hw_single = sec_sel_reg[c] ? SEC_SINGLE_REQ[c] : SINGLE_REQ[c];
      // last gather task takes bursts only
      assign tail_burst = ctl_reg[cs][`DCC_B_TAIL] && (tasks_reg[c] == `DCC_CNT_W'(1))
                          && (ctl_reg[cs][`DCC_F_MODE] == mode_periph_sg);
      assign req_set[c] = en_reg[c] && ((sw_req_w && WDATA[c]) || (!request_mask_attr[c]
                          && (hw_burst || (hw_single && !burst_only_attr[c] && !tail_burst))));
      assign req_burst[c] = (sw_req_w && WDATA[c]) || hw_burst;

      // masked hardware request never becomes pending
      a_mask_blocks: assert property (request_mask_attr[c] && !pend_reg[c]
        && !(sw_req_w && WDATA[c]) && !(keep_going && chunk_end && ch_reg == 2'(c))
        |=> !pend_reg[c]) else $error("masked request became pending");
      a_burst_only: assert property (burst_only_attr[c] && !hw_burst && !pend_reg[c]
        && !(sw_req_w && WDATA[c]) && !(state_reg == ST_MOVE && ch_reg == 2'(c))
        && !(state_reg == ST_DONE && ch_reg == 2'(c))
        |=> !pend_reg[c]) else $error("single request taken under burst-only");
      // software request pends an enabled channel
      a_sw_request: assert property (sw_req_w && WDATA[c] && en_reg[c]
        && !(state_reg == ST_DONE && fin && ch_reg == 2'(c))
        |=> pend_reg[c]) else $error("software request lost");
    end
  endgenerate

  dcc_arbiter u_arb (
    .req(pend_reg & en_reg),
    .high(high_attr),
    .valid(gnt_valid),
    .idx(gnt_idx)
  );

  // engine sequence
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      ch_reg <= 2'h0;
      chunk_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (gnt_valid) begin
            ch_reg <= gnt_idx;
            state_reg <= ST_GRANT;
          end
        end
        ST_GRANT: begin
          chunk_reg <= chunk_load;
          state_reg <= go ? ST_MOVE : ST_IDLE;
        end
        ST_MOVE: begin
          chunk_reg <= chunk_reg - `DCC_CNT_W'(1);
          if (cnt_reg[s_idx] == `DCC_CNT_W'(1)) begin
            state_reg <= ST_DONE;
          end else if (chunk_reg == `DCC_CNT_W'(1)) begin
            // give the bus back after the chunk
            state_reg <= ST_IDLE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // pending requests: a new request wins over the grant clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pend_reg <= '0;
      pend_burst_reg <= '0;
    end else begin
      for (int i = 0; i < `DCC_NCH; i++) begin
        if (state_reg == ST_DONE && fin && ch_reg == 2'(i)) begin
          // a held request must not outlive the served transfer
          pend_reg[i] <= 1'b0;
        end else if (req_set[i]) begin
          pend_reg[i] <= 1'b1;
          pend_burst_reg[i] <= req_burst[i];
        end else if ((chunk_end || (state_reg == ST_DONE && !fin))
                     && keep_going && ch_reg == 2'(i)) begin
          // auto and memory gather continue without a new request
          pend_reg[i] <= 1'b1;
          pend_burst_reg[i] <= 1'b1;
        end else if (state_reg == ST_GRANT && ch_reg == 2'(i)) begin
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  // channel enables
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      en_reg <= '0;
    end else begin
      for (int i = 0; i < `DCC_NCH; i++) begin
        if (WR && ADDR == `DCC_A_EN_SET && WDATA[i]) begin
          en_reg[i] <= 1'b1;
        end else if (WR && ADDR == `DCC_A_EN_CLR && WDATA[i]) begin
          en_reg[i] <= 1'b0;
        end else if (state_reg == ST_DONE && fin && ch_reg == 2'(i)) begin
          en_reg[i] <= 1'b0;
        end
      end
    end
  end

  // attributes and source select
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      attr_reg <= '0;
      sec_sel_reg <= '0;
    end else begin
      if (state_reg == ST_DONE && act_mode == mode_ping_pong) begin
        attr_reg[`DCC_AT_W*ch_reg + `DCC_AT_ALT] <= !alternate_struct_attr[ch_reg];
      end
      if (WR && ADDR == `DCC_A_ATTR_SET) begin
        attr_reg <= attr_reg | WDATA[`DCC_AT_W*`DCC_NCH-1:0];
      end else if (WR && ADDR == `DCC_A_ATTR_CLR) begin
        attr_reg <= attr_reg & ~WDATA[`DCC_AT_W*`DCC_NCH-1:0];
      end
      if (WR && ADDR == `DCC_A_SEL_DEF) begin
        sec_sel_reg <= sec_sel_reg & ~WDATA[`DCC_NCH-1:0];
      end else if (WR && ADDR == `DCC_A_SEL_SEC) begin
        sec_sel_reg <= sec_sel_reg | WDATA[`DCC_NCH-1:0];
      end
    end
  end

  // scatter-gather setup and task progress
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      psg_reg <= '0;
      for (int i = 0; i < `DCC_NCH; i++) begin
        tasks_reg[i] <= '0;
      end
    end else begin
      // one task consumed per finished task except the last, which leaves the count at 1
      if (state_reg == ST_DONE && more_tasks) begin
        tasks_reg[ch_reg] <= tasks_reg[ch_reg] - `DCC_CNT_W'(1);
      end
      if (WR && ADDR >= `DCC_A_SG_BASE && ADDR <= `DCC_A_SG_LAST) begin
        tasks_reg[ADDR[3:2]] <= WDATA[`DCC_F_TASKS];
        psg_reg[ADDR[3:2]] <= WDATA[`DCC_B_PSG];
      end
    end
  end

  // control structures; no guard against rewriting a live structure
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      for (int i = 0; i < NS; i++) begin
        ctl_reg[i] <= '0;
        src_reg[i] <= '0;
        dst_reg[i] <= '0;
        cnt_reg[i] <= '0;
        init_reg[i] <= '0;
      end
    end else begin
      if (state_reg == ST_MOVE) begin
        src_reg[s_idx] <= src_reg[s_idx] + step_of(act_ctl[`DCC_F_SINC]);
        dst_reg[s_idx] <= dst_reg[s_idx] + step_of(act_ctl[`DCC_F_DINC]);
        cnt_reg[s_idx] <= cnt_reg[s_idx] - `DCC_CNT_W'(1);
      end else if (state_reg == ST_DONE) begin
        if (more_tasks) begin
          cnt_reg[s_idx] <= init_reg[s_idx];
        end else begin
          ctl_reg[s_idx][`DCC_F_MODE] <= mode_stop;
        end
      end
      // each structure written on its own
      if (wr_struct) begin
        unique case (bus_word)
          `DCC_W_CTL: ctl_reg[bus_sidx] <= WDATA[`DCC_CTL_W-1:0];
          `DCC_W_SRC: src_reg[bus_sidx] <= WDATA;
          `DCC_W_DST: dst_reg[bus_sidx] <= WDATA;
          `DCC_W_CNT: begin
            cnt_reg[bus_sidx] <= WDATA[`DCC_CNT_W-1:0];
            init_reg[bus_sidx] <= WDATA[`DCC_CNT_W-1:0];
          end
        endcase
      end
    end
  end

  // item strobe towards the memory side
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ITEM_STB <= 1'b0;
      ITEM_CH <= 2'h0;
      ITEM_SIZE <= 2'h0;
      ITEM_SRC <= '0;
      ITEM_DST <= '0;
    end else begin
      ITEM_STB <= (state_reg == ST_MOVE);
      if (state_reg == ST_MOVE) begin
        ITEM_CH <= ch_reg;
        ITEM_SIZE <= act_ctl[`DCC_F_SIZE];
        ITEM_SRC <= src_reg[s_idx];
        ITEM_DST <= dst_reg[s_idx];
      end
    end
  end

  // completion signalling
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DMA_IRQ <= 1'b0;
      PERIPH_DONE <= '0;
    end else begin
      // software channel uses the controller interrupt
      DMA_IRQ <= (state_reg == ST_DONE) && fin && (ch_reg == `DCC_SW_CH);
      for (int i = 0; i < `DCC_NCH; i++) begin
        PERIPH_DONE[i] <= (state_reg == ST_DONE) && fin && (ch_reg == 2'(i))
                          && (ch_reg != `DCC_SW_CH);
      end
    end
  end

  // register read, data in the following cycle only
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA <= '0;
    end else if (!RD) begin
      RDATA <= '0;
    end else if (ADDR[`DCC_B_STRUCT]) begin
      unique case (bus_word)
        `DCC_W_CTL: RDATA <= {17'h0, ctl_reg[bus_sidx]};
        `DCC_W_SRC: RDATA <= src_reg[bus_sidx];
        `DCC_W_DST: RDATA <= dst_reg[bus_sidx];
        `DCC_W_CNT: RDATA <= {21'h0, cnt_reg[bus_sidx]};
      endcase
    end else if (ADDR >= `DCC_A_SG_BASE && ADDR <= `DCC_A_SG_LAST) begin
      RDATA <= {19'h0, psg_reg[ADDR[3:2]], 1'b0, tasks_reg[ADDR[3:2]]};
    end else begin
      unique case (ADDR)
        `DCC_A_EN_SET: RDATA <= {28'h0, en_reg};
        `DCC_A_ATTR_SET: RDATA <= {16'h0, attr_reg};
        `DCC_A_SEL_SEC: RDATA <= {28'h0, sec_sel_reg};
        `DCC_A_STATUS: RDATA <= {28'h0, state_reg, ch_reg};
        default: RDATA <= '0;
      endcase
    end
  end

  logic [`DCC_NCH-1:0] lower_req;
  logic [`DCC_NCH-1:0] live_req;
  assign live_req = pend_reg & en_reg;
  assign lower_req = live_req & ((4'h1 << gnt_idx) - 4'h1);

  a_grant_order: assert property (gnt_valid |-> ((lower_req
    & (high_attr | {`DCC_NCH{!high_attr[gnt_idx]}})) == '0)
    && (high_attr[gnt_idx] || (live_req & high_attr) == '0)) else $error("wrong grant");
  a_disabled_drop: assert property (state_reg == ST_GRANT && !en_reg[ch_reg]
    |=> state_reg == ST_IDLE ##1 !ITEM_STB) else $error("disabled channel moved data");
  a_auto_disable: assert property (state_reg == ST_DONE && fin
    && !(WR && ADDR == `DCC_A_EN_SET)
    |=> !en_reg[$past(ch_reg)]) else $error("enable kept after completion");
  a_mode_stop: assert property (state_reg == ST_DONE && fin && !wr_struct
    |=> ctl_reg[$past(s_idx)][`DCC_F_MODE] == mode_stop) else $error("mode not stopped");
  a_irq_route: assert property (state_reg == ST_DONE && fin
    |=> (DMA_IRQ == ($past(ch_reg) == `DCC_SW_CH))
    && (PERIPH_DONE != '0) == ($past(ch_reg) != `DCC_SW_CH)) else $error("irq misrouted");
  a_chunk_size: assert property (state_reg == ST_GRANT && go
    |=> state_reg == ST_MOVE && chunk_reg == $past(chunk_load)) else $error("bad chunk");
  a_count_step: assert property (state_reg == ST_MOVE && !wr_struct
    |=> cnt_reg[$past(s_idx)] == $past(cnt_reg[s_idx]) - `DCC_CNT_W'(1)
    ##0 ITEM_STB) else $error("count not stepped");
  a_src_fixed: assert property (state_reg == ST_MOVE && act_ctl[`DCC_F_SINC] == `DCC_INC_NONE
    && !wr_struct |=> src_reg[$past(s_idx)] == $past(src_reg[s_idx])) else $error("src moved");

  c_sw_done: cover property (state_reg == ST_DONE && fin && ch_reg == `DCC_SW_CH);
  c_ping_pong: cover property (state_reg == ST_DONE && act_mode == mode_ping_pong && !fin);
  c_rearbitrate: cover property (chunk_end ##1 state_reg == ST_IDLE);
endmodule

// [inc/dcc_defines.svh]
// constants of the dma channel control block
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_NCH 4
`define DCC_SW_CH 2'h3
`define DCC_ADDR_W 8
`define DCC_CNT_W 11
// register byte addresses
`define DCC_A_EN_SET 8'h00
`define DCC_A_EN_CLR 8'h04
`define DCC_A_ATTR_SET 8'h08
`define DCC_A_ATTR_CLR 8'h0c
`define DCC_A_SW_REQ 8'h10
`define DCC_A_SEL_DEF 8'h14
`define DCC_A_SEL_SEC 8'h18
`define DCC_A_STATUS 8'h1c
`define DCC_A_SG_BASE 8'h20
`define DCC_A_SG_LAST 8'h2c
// structure window: addr[7] set, addr[6:4] structure, addr[3:2] field
`define DCC_B_STRUCT 7
`define DCC_F_SIDX 6:4
`define DCC_F_WORD 3:2
`define DCC_W_CTL 2'h0
`define DCC_W_SRC 2'h1
`define DCC_W_DST 2'h2
`define DCC_W_CNT 2'h3
// attribute bit within each channel nibble
`define DCC_AT_BURST 0
`define DCC_AT_ALT 1
`define DCC_AT_HIGH 2
`define DCC_AT_MASK 3
`define DCC_AT_W 4
// control word fields
`define DCC_F_SIZE 1:0
`define DCC_F_SINC 3:2
`define DCC_F_DINC 5:4
`define DCC_F_ARB 9:6
`define DCC_B_TAIL 10
`define DCC_F_MODE 14:12
`define DCC_CTL_W 15
`define DCC_ARB_MAX 4'ha
`define DCC_INC_NONE 2'h3
// scatter-gather word fields
`define DCC_F_TASKS 10:0
`define DCC_B_PSG 12
`endif

// [inc/dcc_pkg.sv]
// types of the dma channel control block
package dcc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GRANT = 2'b01,
    ST_MOVE = 2'b11,
    ST_DONE = 2'b10
  } dcc_state_t;
  typedef enum logic [2:0] {
    mode_stop = 3'h0,
    mode_basic = 3'h1,
    mode_auto = 3'h2,
    mode_ping_pong = 3'h3,
    mode_mem_sg = 3'h4,
    mode_periph_sg = 3'h5
  } dcc_mode_t;
endpackage

// [tb/dcc_periph_model.sv]
// peripheral side model: request lines held until the channel reports done
`timescale 1ns/1ps
module dcc_periph_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] arm,
  input wire logic burst,
  input wire logic sec,
  input wire logic [3:0] done,
  output logic [3:0] breq,
  output logic [3:0] sreq,
  output logic [3:0] sbreq,
  output logic [3:0] ssreq
);
  logic [3:0] pend_reg;
  // a real peripheral keeps asking until its transfer finished
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 4'h0;
    end else begin
      pend_reg <= (pend_reg | arm) & ~done;
    end
  end
  assign breq = (burst && !sec) ? pend_reg : 4'h0;
  assign sreq = (!burst && !sec) ? pend_reg : 4'h0;
  assign sbreq = (burst && sec) ? pend_reg : 4'h0;
  assign ssreq = (!burst && sec) ? pend_reg : 4'h0;
endmodule

// [tb/dma_channel_control_tb_top.sv]
// self-checking bench of the dma channel control block
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dma_channel_control_tb_top;
  import dcc_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA, ITEM_SRC, ITEM_DST;
  logic [3:0] breq, sreq, sbreq, ssreq, pdone;
  logic [3:0] arm = 4'h0;
  logic burst = 1'b0;
  logic sec = 1'b0;
  logic ITEM_STB, DMA_IRQ;
  logic [1:0] ITEM_CH, ITEM_SIZE;
  int num_errors = 0;
  int samples_checked = 0;
  int irq_cnt = 0;
  int pd_cnt = 0;
  logic [67:0] obs[$];
  logic [67:0] exp_q[$];

  always #50 CLK_SYS = ~CLK_SYS;

  dcc_channel_ctrl i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .BURST_REQ(breq), .SINGLE_REQ(sreq), .SEC_BURST_REQ(sbreq),
    .SEC_SINGLE_REQ(ssreq), .ITEM_STB(ITEM_STB), .ITEM_CH(ITEM_CH), .ITEM_SIZE(ITEM_SIZE),
    .ITEM_SRC(ITEM_SRC), .ITEM_DST(ITEM_DST), .DMA_IRQ(DMA_IRQ), .PERIPH_DONE(pdone));

  dcc_periph_model i_periph (.clk(CLK_SYS), .rst(RST), .arm(arm), .burst(burst), .sec(sec),
    .done(pdone), .breq(breq), .sreq(sreq), .sbreq(sbreq), .ssreq(ssreq));

  always @(posedge CLK_SYS) begin
    if (ITEM_STB === 1'b1) obs.push_back({ITEM_CH, ITEM_SIZE, ITEM_SRC, ITEM_DST});
    if (DMA_IRQ === 1'b1) irq_cnt++;
    if (pdone !== 4'h0) pd_cnt++;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [67:0] got, input logic [67:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string msg);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    chk({36'h0, RDATA}, {36'h0, e}, msg);
  endtask

  // program the primary structure, enable, and queue the expected items
  task automatic setup(input int ch, input int sz, input int si, input int di, input int arb,
                       input int mode, input int n, input int t);
    logic [7:0] b;
    logic [31:0] s;
    logic [31:0] d;
    // structures live in fixed aligned slots of the window
    b = 8'h80 + 8'(32 * ch);
    s = $urandom & 32'hffff_fffc;
    d = $urandom & 32'hffff_fffc;
    wr(b, 32'(sz | si << 2 | di << 4 | arb << 6 | mode << 12));
    wr(b + 8'h04, s);
    wr(b + 8'h08, d);
    wr(b + 8'h0c, 32'(n));
    wr(`DCC_A_SG_BASE + 8'(4 * ch), 32'(t));
    wr(`DCC_A_EN_SET, 32'(1 << ch));
    for (int i = 0; i < n * t; i++) begin
      exp_q.push_back({2'(ch), 2'(sz), s + 32'(i * (si == 3 ? 0 : 1 << si)),
                       d + 32'(i * (di == 3 ? 0 : 1 << di))});
    end
  endtask

  task automatic finish_xfer(input int e_irq, input int e_pd);
    for (int k = 0; k < 300 && irq_cnt + pd_cnt < e_irq + e_pd; k++) @(posedge CLK_SYS);
    repeat (3) @(posedge CLK_SYS);
    chk(68'(obs.size()), 68'(exp_q.size()), "item count");
    while (obs.size() > 0 && exp_q.size() > 0) chk(obs.pop_front(), exp_q.pop_front(), "item");
    chk(68'(irq_cnt), 68'(e_irq), "sw irq");
    chk(68'(pd_cnt), 68'(e_pd), "periph done");
    obs.delete();
    exp_q.delete();
    irq_cnt = 0;
    pd_cnt = 0;
  endtask

  // an absent transfer can only be seen over an observation span
  task automatic quiet(input string msg);
    repeat (30) @(posedge CLK_SYS);
    chk(68'(obs.size()), 68'h0, msg);
  endtask

  initial begin
    logic [31:0] r;
    void'($urandom(32'h3c76));
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    rd(`DCC_A_EN_SET, 32'h0, "enable after reset");
    rd(`DCC_A_ATTR_SET, 32'h0, "attr after reset");
    rd(8'h7c, 32'h0, "unmapped");
    r = $urandom & 32'hffff;
    wr(`DCC_A_ATTR_SET, r);
    rd(`DCC_A_ATTR_SET, r, "attr set");
    wr(`DCC_A_ATTR_CLR, 32'hffff);
    rd(`DCC_A_ATTR_SET, 32'h0, "attr clear");
    wr(8'h90, 32'h1155);
    rd(8'h90, 32'h1155, "alternate ctl");
    rd(8'h80, 32'h0, "primary ctl");
    for (int sz = 0; sz < 3; sz++) begin
      setup(3, sz, sz, sz + 1, sz, 2, 3, 1);
      wr(`DCC_A_SW_REQ, 32'h8);
      finish_xfer(1, 0);
      rd(`DCC_A_EN_SET, 32'h0, "auto disable");
      rd(8'he0, 32'(sz | sz << 2 | (sz + 1) << 4 | sz << 6), "mode stop");
      rd(8'hec, 32'h0, "remaining");
    end
    // fixed source pointer, two gather tasks of two bytes
    setup(3, 0, 3, 0, 0, 4, 2, 2);
    wr(`DCC_A_SW_REQ, 32'h8);
    finish_xfer(1, 0);
    rd(`DCC_A_SG_LAST, 32'h1, "tasks left");
    rd(8'he0, 32'hc, "gather stop");
    rd(8'hec, 32'h0, "gather remaining");
    setup(0, 2, 2, 2, 0, 1, 2, 1);
    wr(`DCC_A_EN_CLR, 32'h1);
    arm <= 4'h1;
    @(posedge CLK_SYS);
    arm <= 4'h0;
    quiet("disabled channel");
    wr(`DCC_A_ATTR_SET, 32'h8);
    wr(`DCC_A_EN_SET, 32'h1);
    quiet("masked channel");
    wr(`DCC_A_ATTR_SET, 32'h1);
    wr(`DCC_A_ATTR_CLR, 32'h8);
    quiet("single on burst only");
    wr(`DCC_A_SEL_SEC, 32'h1);
    rd(`DCC_A_SEL_SEC, 32'h1, "select read");
    burst <= 1'b1;
    quiet("default source off");
    sec <= 1'b1;
    finish_xfer(0, 1);
    wr(`DCC_A_SEL_DEF, 32'hf);
    rd(`DCC_A_SEL_SEC, 32'h0, "select default");
    wr(`DCC_A_ATTR_CLR, 32'hffff);
    wr(`DCC_A_ATTR_SET, 32'h40);
    setup(1, 2, 2, 2, 0, 2, 1, 1);
    setup(0, 2, 2, 2, 0, 2, 1, 1);
    wr(`DCC_A_SW_REQ, 32'h3);
    finish_xfer(0, 2);
    wr(`DCC_A_ATTR_CLR, 32'h40);
    setup(0, 2, 2, 2, 0, 2, 1, 1);
    setup(1, 2, 2, 2, 0, 2, 1, 1);
    wr(`DCC_A_SW_REQ, 32'h3);
    finish_xfer(0, 2);
    close_out();
  end

  initial begin
    #2_000_000;
    num_errors++;
    close_out();
  end
endmodule
